// ---- irq_prio_consts.vh ----
// Functional notes
// - high-priority vector is 0008h, low-priority vector is 0018h.
// - an enabled high request preempts a low service in progress.
// - no low request is taken while a high service runs.
// - every source has a flag, an enable and a priority bit.
// - priority enable clear at reset; priority bits then ignored.
// - compatibility: peripheral sources need peripheral and global enable.
// - compatibility: global enable admits core sources, clear blocks all.
// - compatibility: every accepted interrupt goes to 0008h.
// - priority mode set by priority enable in reset control register.
// - priority mode: high enable admits high sources, clear blocks all.
// - priority mode: low sources need both low and high enables.
// - flag, enable and global enable set vectors at once by priority.
// - acceptance clears the global enable of the accepted level.
// - acceptance pushes return address and loads vector into PC.
// - return from interrupt sets the level's global enable again.
// - pin and port-change latency is three to four instruction cycles.
// - flags set on events regardless of any enable bit.
// - clearing a source enable stops only that source's vectoring.
`ifndef IRQ_PRIO_CONSTS_VH
`define IRQ_PRIO_CONSTS_VH

`define NSRC 16
`define NPERIPH_LO 8
`define VEC_HIGH 21'h000008
`define VEC_LOW 21'h000018
`define PC_W 21

`define REG_CTRL 8'h00
`define REG_FLAG 8'h04
`define REG_ENABLE 8'h08
`define REG_PRIO 8'h0C
`define REG_STATUS 8'h10
`define REG_FLAG_CLR 8'h14

`define CTRL_GEH 0
`define CTRL_PEL 1
`define CTRL_PRIO_EN 2

`define LAT_SYNC 2

`endif

// ---- two_level_interrupt_priority_ctrl.v ----
`include "irq_prio_consts.vh"

// sources 0..7 are core (non-peripheral) sources, 8..15 peripheral ones
module two_level_interrupt_priority_ctrl (
    input wire aclk, // 250 MHz clock
    input wire aresetn, // sync reset, active low
    input wire [`NSRC-1:0] event_pulse, // per-source event strobes
    input wire instr_boundary, // core finishing an instruction this cycle
    input wire return_from_interrupt, // core executes return-from-interrupt
    input wire [`PC_W-1:0] pc_current, // address of next instruction
    output reg vector_req_q, // one-cycle: load vector into PC
    output reg [`PC_W-1:0] vector_addr_q, // vector to load
    output reg stack_push_q, // one-cycle: push return address
    output reg [`PC_W-1:0] push_addr_q, // return address to push
    output reg in_service_high_q, // high level in service
    output reg in_service_low_q, // low level in service
    input wire [7:0] s_axi_awaddr, // AXI4-Lite write address
    input wire s_axi_awvalid, // write address valid
    output reg s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // write strobes
    input wire s_axi_wvalid, // write data valid
    output reg s_axi_wready, // write data ready
    output reg [1:0] s_axi_bresp, // write response
    output reg s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [7:0] s_axi_araddr, // read address
    input wire s_axi_arvalid, // read address valid
    output reg s_axi_arready, // read address ready
    output reg [31:0] s_axi_rdata, // read data
    output reg [1:0] s_axi_rresp, // read response
    output reg s_axi_rvalid, // read data valid
    input wire s_axi_rready // read data ready
);

    reg [`NSRC-1:0] flag_q;
    reg [`NSRC-1:0] enable_q;
    reg [`NSRC-1:0] prio_q;
    reg global_enable_high_q;
    reg peripheral_enable_low_q;
    reg priority_enable_q;
    reg [`LAT_SYNC-1:0] arm_q;
    reg [`LAT_SYNC-1:0] arm_lo_q;

    reg aw_got_q, w_got_q;
    reg [7:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    wire do_write = aw_got_q && w_got_q && !s_axi_bvalid;
    wire [`NSRC-1:0] flag_set_w = do_write && aw_addr_q == `REG_FLAG ?
        w_data_q[`NSRC-1:0] : {`NSRC{1'b0}};
    wire [`NSRC-1:0] flag_clr_w = do_write && aw_addr_q == `REG_FLAG_CLR ?
        w_data_q[`NSRC-1:0] : {`NSRC{1'b0}};

    // per-source qualification
    wire [`NSRC-1:0] pend_w = flag_q & enable_q;
    wire [`NSRC-1:0] periph_mask_w = {{(`NSRC-`NPERIPH_LO){1'b1}},
        {`NPERIPH_LO{1'b0}}};
    reg take_high, take_low;
    always @* begin
        take_high = 1'b0;
        take_low = 1'b0;
        if (!priority_enable_q) begin
            // peripherals also need the peripheral enable
            take_high = global_enable_high_q && !in_service_high_q &&
                (|(pend_w & ~periph_mask_w) ||
                 (peripheral_enable_low_q && |(pend_w & periph_mask_w)));
        end else begin
            take_high = global_enable_high_q && !in_service_high_q &&
                |(pend_w & prio_q);
            take_low = global_enable_high_q && peripheral_enable_low_q &&
                !in_service_high_q && !in_service_low_q &&
                |(pend_w & ~prio_q);
        end
    end

    // requests are held two cycles, then taken at an instruction boundary;
    // this places the vector 3..4 instruction cycles after the event
    wire accept_high = arm_q[`LAT_SYNC-1] && take_high && instr_boundary;
    wire accept_low = arm_lo_q[`LAT_SYNC-1] && take_low && instr_boundary &&
        !accept_high;

    always @(posedge aclk) begin
        if (!aresetn) begin
            flag_q <= {`NSRC{1'b0}};
            enable_q <= {`NSRC{1'b0}};
            prio_q <= {`NSRC{1'b1}};
            global_enable_high_q <= 1'b0;
            peripheral_enable_low_q <= 1'b0;
            priority_enable_q <= 1'b0;
            arm_q <= {`LAT_SYNC{1'b0}};
            arm_lo_q <= {`LAT_SYNC{1'b0}};
            in_service_high_q <= 1'b0;
            in_service_low_q <= 1'b0;
            vector_req_q <= 1'b0;
            vector_addr_q <= {`PC_W{1'b0}};
            stack_push_q <= 1'b0;
            push_addr_q <= {`PC_W{1'b0}};
        end else begin
            // set wins over software clear
            flag_q <= (flag_q & ~flag_clr_w) | flag_set_w | event_pulse;
            arm_q <= {arm_q[`LAT_SYNC-2:0], take_high};
            arm_lo_q <= {arm_lo_q[`LAT_SYNC-2:0], take_low};
            vector_req_q <= accept_high || accept_low;
            stack_push_q <= accept_high || accept_low;
            if (accept_high || accept_low) begin
                push_addr_q <= pc_current;
                arm_q <= {`LAT_SYNC{1'b0}};
                arm_lo_q <= {`LAT_SYNC{1'b0}};
            end
            if (accept_high) begin
                vector_addr_q <= `VEC_HIGH;
                global_enable_high_q <= 1'b0;
                in_service_high_q <= 1'b1;
            end else if (accept_low) begin
                vector_addr_q <= `VEC_LOW;
                peripheral_enable_low_q <= 1'b0;
                in_service_low_q <= 1'b1;
            end else if (return_from_interrupt) begin
                // the innermost level returns: high if it is active or priority mode is off, else low
                if (in_service_high_q || !priority_enable_q) begin
                    global_enable_high_q <= 1'b1;
                    in_service_high_q <= 1'b0;
                end else if (in_service_low_q) begin
                    peripheral_enable_low_q <= 1'b1;
                    in_service_low_q <= 1'b0;
                end
            end else if (do_write && aw_addr_q == `REG_CTRL &&
                         w_strb_q[0]) begin
                global_enable_high_q <= w_data_q[`CTRL_GEH];
                peripheral_enable_low_q <= w_data_q[`CTRL_PEL];
                priority_enable_q <= w_data_q[`CTRL_PRIO_EN];
            end
            if (do_write && aw_addr_q == `REG_ENABLE)
                enable_q <= w_data_q[`NSRC-1:0];
            if (do_write && aw_addr_q == `REG_PRIO)
                prio_q <= w_data_q[`NSRC-1:0];
        end
    end

    // write channel: address and data taken in either order or in the same cycle, one write at a time
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else begin
            s_axi_awready <= !aw_got_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_got_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                case (aw_addr_q)
                    `REG_CTRL, `REG_FLAG, `REG_ENABLE, `REG_PRIO,
                    `REG_FLAG_CLR: s_axi_bresp <= 2'h0;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
            end
        end
    end

    // read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (s_axi_araddr)
                    `REG_CTRL: s_axi_rdata <= {29'h0, priority_enable_q,
                        peripheral_enable_low_q, global_enable_high_q};
                    `REG_FLAG: s_axi_rdata <= {16'h0, flag_q};
                    `REG_ENABLE: s_axi_rdata <= {16'h0, enable_q};
                    `REG_PRIO: s_axi_rdata <= {16'h0, prio_q};
                    `REG_STATUS: s_axi_rdata <= {30'h0, in_service_low_q,
                        in_service_high_q};
                    `REG_FLAG_CLR: s_axi_rdata <= 32'h00000000;
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // two_level_interrupt_priority_ctrl

// ---- irq_prio_sva.sv ----
`include "irq_prio_consts.vh"
module irq_prio_sva (
    input wire aclk, // clock
    input wire aresetn, // reset
    input wire return_from_interrupt, // return
    input wire vector_req_q, // load pc
    input wire [`PC_W-1:0] vector_addr_q, // vector
    input wire stack_push_q, // push
    input wire in_service_high_q, // high busy
    input wire in_service_low_q, // low busy
    input wire s_axi_bvalid, // b valid
    input wire s_axi_bready, // b ready
    input wire s_axi_rvalid, // r valid
    input wire s_axi_rready, // r ready
    input wire [31:0] s_axi_rdata // r data
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_push_vec_pair: assert property (vector_req_q == stack_push_q)
        else $error("push without vector");
    a_vec_addr_ok: assert property (vector_req_q |->
        vector_addr_q == `VEC_HIGH || vector_addr_q == `VEC_LOW)
        else $error("bad vector address");
    a_high_svc_vec: assert property ($rose(in_service_high_q) |->
        ##[0:1] (vector_req_q && vector_addr_q == `VEC_HIGH))
        else $error("high service without high vector");
    a_low_svc_vec: assert property ($rose(in_service_low_q) |->
        ##[0:1] (vector_req_q && vector_addr_q == `VEC_LOW))
        else $error("low service without low vector");
    a_no_low_in_high: assert property (in_service_high_q &&
        $past(in_service_high_q) |-> !(vector_req_q && vector_addr_q == `VEC_LOW))
        else $error("low vector during high service");
    a_ret_ends_high: assert property ($fell(in_service_high_q) |->
        $past(return_from_interrupt))
        else $error("high service ended without return");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid)
        else $error("bvalid dropped early");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed early");
endmodule // irq_prio_sva
bind two_level_interrupt_priority_ctrl irq_prio_sva u_irq_prio_sva (.*);

// ---- cpu_core_model.sv ----
`include "irq_prio_consts.vh"
module cpu_core_model (
    input wire aclk, // clock
    input wire aresetn, // reset
    input wire slow, // two-cycle instructions
    input wire ret_req, // run a return
    input wire vector_req_q, // load pc
    input wire [`PC_W-1:0] vector_addr_q, // vector
    input wire stack_push_q, // push
    input wire [`PC_W-1:0] push_addr_q, // return address
    output reg instr_boundary, // boundary
    output reg return_from_interrupt, // return pulse
    output reg [`PC_W-1:0] pc_current // next address
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [`PC_W-1:0] stack_q [0:7];
    reg [2:0] sp_q;
    always @(posedge aclk) begin
        if (!aresetn) begin
            instr_boundary <= 1'b0;
            return_from_interrupt <= 1'b0;
            pc_current <= 21'h000100;
            sp_q <= 3'h0;
        end else begin
            instr_boundary <= !slow || !instr_boundary;
            return_from_interrupt <= ret_req;
            pc_current <= pc_current + 21'h000002;
            if (stack_push_q) begin
                stack_q[sp_q] <= push_addr_q;
                sp_q <= sp_q + 3'h1;
            end
            if (vector_req_q) pc_current <= vector_addr_q;
            if (return_from_interrupt) begin
                pc_current <= stack_q[sp_q - 3'h1];
                sp_q <= sp_q - 3'h1;
            end
        end
    end
endmodule // cpu_core_model

// ---- two_level_interrupt_priority_ctrl_tb.sv ----
`include "irq_prio_consts.vh"
module two_level_interrupt_priority_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, slow, ret_req, hit, s_axi_awvalid, s_axi_wvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [15:0] event_pulse;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    wire instr_boundary, return_from_interrupt, vector_req_q, stack_push_q;
    wire in_service_high_q, in_service_low_q, s_axi_awready, s_axi_wready;
    wire s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [`PC_W-1:0] pc_current, vector_addr_q, push_addr_q;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer fails, n_tests, cyc;
    two_level_interrupt_priority_ctrl u_two_level_interrupt_priority_ctrl (.*);
    cpu_core_model u_cpu_core_model (.*);
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        // status is read-only, so a write there is refused like a hole
        chk("bresp", {30'h0, s_axi_bresp},
            (a == `REG_STATUS || a > 8'h14) ? 32'h2 : 32'h0);
    endtask
    task rchk(input [7:0] a, input [31:0] exp, input string nm);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(nm, s_axi_rdata, exp);
        chk("rresp", {30'h0, s_axi_rresp}, (a > 8'h14) ? 32'h2 : 32'h0);
    endtask
    task ev(input integer s);
        @(posedge aclk);
        event_pulse <= 16'h0001 << s;
        @(posedge aclk);
        event_pulse <= 16'h0000;
    endtask
    // fixed window; only the first vector in it is checked, a repeated one is ignored
    task wvec(input logic want, input [`PC_W-1:0] exp);
        hit = 1'b0;
        repeat (16) begin
            @(posedge aclk);
            if (vector_req_q !== 1'b0 && !hit) begin
                hit = 1'b1;
                chk("vector", {11'h0, vector_addr_q}, {11'h0, exp});
                // the core model steps two bytes per cycle, so the address
                // taken at the accept edge trails the one now shown by two
                chk("push", {11'h0, push_addr_q},
                    {11'h0, pc_current - 21'h000002});
            end
        end
        chk("vec_seen", {31'h0, hit}, {31'h0, want});
    endtask
    task ret;
        @(posedge aclk);
        ret_req <= 1'b1;
        @(posedge aclk);
        ret_req <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    task t_compat;
        rchk(`REG_CTRL, 32'h0, "ctrl");
        rchk(`REG_PRIO, 32'h0000FFFF, "prio");
        rchk(8'h40, 32'h0, "unmapped");
        wr(`REG_PRIO, 32'h0);
        wr(`REG_ENABLE, 32'h00000202);
        wr(`REG_CTRL, 32'h00000001);
        ev(9);
        wvec(1'b0, 21'h0);
        rchk(`REG_FLAG, 32'h00000200, "flag");
        ev(1);
        wvec(1'b1, `VEC_HIGH);
        rchk(`REG_CTRL, 32'h0, "ctrl");
        wr(`REG_FLAG_CLR, 32'h000000FF);
        ret;
        rchk(`REG_CTRL, 32'h00000001, "ctrl");
        wr(`REG_CTRL, 32'h00000003);
        wvec(1'b1, `VEC_HIGH);
        wr(`REG_FLAG_CLR, 32'h0000FFFF);
        ret;
    endtask
    task t_prio;
        slow <= 1'b1;
        wr(`REG_PRIO, 32'h00000008);
        wr(`REG_ENABLE, 32'h0000000C);
        wr(`REG_CTRL, 32'h00000005);
        ev(2);
        wvec(1'b0, 21'h0);
        wr(`REG_CTRL, 32'h00000007);
        wvec(1'b1, `VEC_LOW);
        rchk(`REG_CTRL, 32'h00000005, "ctrl");
        ev(3);
        wvec(1'b1, `VEC_HIGH);
        rchk(`REG_STATUS, 32'h00000003, "status");
        wr(`REG_FLAG_CLR, 32'h0000000C);
        ret;
        rchk(`REG_CTRL, 32'h00000005, "ctrl");
        ret;
        rchk(`REG_CTRL, 32'h00000007, "ctrl");
    endtask
    task t_reset;
        wr(`REG_FLAG, 32'h00000001);
        rchk(`REG_FLAG, 32'h00000001, "flag_set");
        wr(`REG_STATUS, 32'h00000003);
        rchk(`REG_STATUS, 32'h00000000, "status");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(`REG_CTRL, 32'h00000000, "ctrl");
        rchk(`REG_FLAG, 32'h00000000, "flag");
        rchk(`REG_PRIO, 32'h0000FFFF, "prio");
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails = fails + 1;
            print_verdict;
        end
    end
    initial begin
        {fails, n_tests, cyc} = 96'h0;
        {aresetn, slow, ret_req, s_axi_awvalid, s_axi_wvalid} = 5'h0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
        {event_pulse, s_axi_awaddr, s_axi_araddr} = 32'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_compat;
        t_prio;
        t_reset;
        print_verdict;
    end
endmodule // two_level_interrupt_priority_ctrl_tb
